//--- logic/lpt_panel_timing.sv
/*
  Passive monochrome panel timing generator: registers, power sequencing,
  pixel data path, and checks.
  Assumes a 40 MHz clk_i, pixel data offered on request, synchronous inputs.
*/
// The address-and-strobe port and the address map were decided locally.
// What this block does
// (RL1) Halve input clock above 25 MHz
// (RL2) Pixel clock follows the optional halving
// (RL3) Outputs start within a frame of enable
// (RL4) Power rises with outputs, no delay
// (RL5) Override set: save stops outputs at once
// (RL6) Override clear: power first, 127 frames later
// (RL7) Leaving save restores outputs and power together
// (RL8) Override drops power, clearing restores it
// (RL9) Line period is display plus blank
// (RL10) Frame pulse setup is period minus 9
// (RL11) Frame pulse holds 9 after line fall
// (RL12) Line pulse high at least 9
// (RL13) Modulation changes 1 after line rise
// (RL14) First shift rise 23 after line fall
// (RL15) First shift fall 2 or 4 later
// (RL16) Four-bit shift: period 4, 2 low 2 high
// (RL17) Eight-bit shift: period 8, 4 low 4 high
// (RL18) Four-bit data on upper nibble, held 2
// (RL19) Eight-bit data on all lines, held 4
// (RL20) Last shift fall to line rise gap
// (RL21) Last shift fall to line fall gap
// (RL22) Display lines from two registers plus one
// (RL23) Blank lines from six-bit field
// (RL24) Blank period is register plus 4, times 8
`timescale 1ns/1ps
`default_nettype none
module lpt_panel_timing import lpt_pkg::*; (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [4:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic hardware_power_save_i,
  output logic pix_req_o,
  input wire logic [7:0] pix_data_i,
  output logic line_pulse_out_o,
  output logic frame_pulse_out_o,
  output logic pixel_shift_clock_o,
  output logic [7:0] panel_pixel_data_o,
  output logic panel_modulation_out_o,
  output logic ac_modulation_o,
  output logic panel_power_enable_o
);
  lpt_raster_if rif ();

  logic [7:0] clk_q;
  logic [7:0] ctl_q;
  logic [6:0] hdp_q;
  logic [9:0] vdp_q;
  logic [4:0] horizontal_blank_period_q;
  logic [2:0] horizontal_blank_period_hi_q;
  logic [5:0] vertical_blank_period_q;
  logic [7:0] rdata_q;
  logic [7:0] rd_d;
  logic [7:0] stat;
  lpt_pwr_e st_q;
  lpt_pwr_e st_d;
  logic [6:0] drain_q;
  logic pwr_q;
  logic active;
  logic en;
  logic ovr;
  logic [7:0] dat_q;

  assign en = ctl_q[LPT_B_EN];
  assign ovr = ctl_q[LPT_B_OVR];

  // Register writes; decode by address chain
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      clk_q <= LPT_RST_CLK; // see (RL1)
      ctl_q <= LPT_RST_REG;
      hdp_q <= LPT_RST_REG[6:0];
      vdp_q <= {2'b00, LPT_RST_REG};
      horizontal_blank_period_q <= LPT_RST_REG[4:0];
      horizontal_blank_period_hi_q <= LPT_RST_REG[7:5];
      vertical_blank_period_q <= LPT_RST_REG[5:0];
    end else if (reg_wr_i) begin
      if (reg_addr_i == LPT_A_CLK) begin
        clk_q <= reg_wdata_i & 8'h10; // Only the halving bit is kept
      end else if (reg_addr_i == LPT_A_CTL) begin
        ctl_q <= reg_wdata_i & 8'h07;
      end else if (reg_addr_i == LPT_A_HDP) begin
        hdp_q <= reg_wdata_i[6:0];
      end else if (reg_addr_i == LPT_A_VDPL) begin
        vdp_q[7:0] <= reg_wdata_i; // see (RL22)
      end else if (reg_addr_i == LPT_A_VDPH) begin
        vdp_q[9:8] <= reg_wdata_i[1:0];
      end else if (reg_addr_i == LPT_A_HORIZONTAL_BLANK_PERIOD) begin
        // Upper bits read back but do not stretch the line
        horizontal_blank_period_q <= reg_wdata_i[4:0]; // see (RL24)
        horizontal_blank_period_hi_q <= reg_wdata_i[7:5];
      end else if (reg_addr_i == LPT_A_VERTICAL_BLANK_PERIOD) begin
        vertical_blank_period_q <= reg_wdata_i[5:0]; // see (RL23)
      end
    end
  end

  // Status: state flags for software
  assign stat = {4'h0, pwr_q, active, st_q == ST_DRAIN, st_q == ST_SAVE};

  // Read mux; unmapped addresses read zero
  always_comb begin
    rd_d = 8'h00;
    if (reg_addr_i == LPT_A_CLK) begin
      rd_d = clk_q;
    end else if (reg_addr_i == LPT_A_CTL) begin
      rd_d = ctl_q;
    end else if (reg_addr_i == LPT_A_HDP) begin
      rd_d = {1'b0, hdp_q};
    end else if (reg_addr_i == LPT_A_VDPL) begin
      rd_d = vdp_q[7:0];
    end else if (reg_addr_i == LPT_A_VDPH) begin
      rd_d = {6'h00, vdp_q[9:8]};
    end else if (reg_addr_i == LPT_A_HORIZONTAL_BLANK_PERIOD) begin
      rd_d = {horizontal_blank_period_hi_q, horizontal_blank_period_q};
    end else if (reg_addr_i == LPT_A_VERTICAL_BLANK_PERIOD) begin
      rd_d = {2'b00, vertical_blank_period_q};
    end else if (reg_addr_i == LPT_A_STAT) begin
      rd_d = stat;
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= reg_rd_i ? rd_d : 8'h00;
    end
  end
  assign reg_rdata_o = rdata_q;

  // Power sequencing
  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_OFF: begin
        if (en && !hardware_power_save_i) begin
          st_d = ST_RUN; // see (RL3)
        end
      end
      ST_RUN: begin
        if (!en) begin
          st_d = ST_OFF;
        end else if (hardware_power_save_i) begin
          st_d = ovr ? ST_SAVE : ST_DRAIN; // see (RL5) see (RL6)
        end
      end
      ST_DRAIN: begin
        if (!en) begin
          st_d = ST_OFF;
        end else if (!hardware_power_save_i) begin
          st_d = ST_RUN; // see (RL7)
        end else if (rif.frame_tick && drain_q == LPT_DRAIN_FR - 7'd1) begin
          st_d = ST_SAVE; // see (RL6)
        end
      end
      ST_SAVE: begin
        if (!hardware_power_save_i) begin
          st_d = en ? ST_RUN : ST_OFF; // see (RL5) see (RL7)
        end
      end
      default: begin
        st_d = ST_OFF;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      st_q <= ST_OFF;
    end else begin
      st_q <= st_d;
    end
  end

  // Frames counted while draining before outputs stop
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || st_q != ST_DRAIN) begin
      drain_q <= 7'd0;
    end else if (rif.frame_tick) begin
      drain_q <= drain_q + 7'd1;
    end
  end

  // Power follows the next state so it rises with the outputs
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      pwr_q <= 1'b0;
    end else begin
      pwr_q <= (st_d == ST_RUN) && !ovr; // see (RL4) see (RL7) see (RL8)
    end
  end

  assign active = (st_q == ST_RUN) || (st_q == ST_DRAIN);

  // Raster configuration
  assign rif.run = active;
  assign rif.eight_bit = ctl_q[LPT_B_8BIT];
  assign rif.horizontal_display_period = hdp_q;
  assign rif.horizontal_blank_period = horizontal_blank_period_q;
  assign rif.vertical_display_period = vdp_q;
  assign rif.vertical_blank_period = vertical_blank_period_q;

  lpt_clkdiv u_div (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .div2_i(clk_q[LPT_B_DIV2]),
    .pix_en_o(rif.pix_en)
  );

  lpt_raster u_ras (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .rif(rif)
  );

  // Data changes with the shift rising edge, so it is stable half a period
  // either side of the fall
  assign pix_req_o = rif.load;
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || !active) begin
      dat_q <= 8'h00;
    end else if (rif.load) begin
      dat_q <= rif.eight_bit ? pix_data_i : {pix_data_i[3:0], 4'h0}; // see (RL18) see (RL19)
    end
  end

  // Pulse, shift and modulation outputs are forced low whenever the panel is idle, data a clock later
  assign line_pulse_out_o = active & rif.line_pulse; // see (RL20) see (RL21)
  assign frame_pulse_out_o = active & rif.frame_pulse;
  assign pixel_shift_clock_o = active & rif.shift_clk;
  assign panel_pixel_data_o = dat_q;
  assign ac_modulation_o = active & rif.ac_mod;
  assign panel_modulation_out_o = active & rif.ac_mod;
  assign panel_power_enable_o = pwr_q;

  // Check helpers: pixel ticks since line rise, line fall, shift rise
  logic lp_prev_q;
  logic [10:0] rcnt_q;
  logic [10:0] fcnt_q;
  logic [10:0] scnt_q;
  logic seen_q;
  logic lp_rise;
  logic lp_fall;
  logic [10:0] line_len;
  assign lp_rise = line_pulse_out_o && !lp_prev_q;
  assign lp_fall = !line_pulse_out_o && lp_prev_q;
  assign line_len = {({1'b0, hdp_q} + 8'd1), 3'b000}
                    + {2'b00, ({1'b0, horizontal_blank_period_q} + 6'd4), 3'b000};

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      lp_prev_q <= 1'b0;
      rcnt_q <= 11'd0;
      fcnt_q <= 11'd0;
      scnt_q <= 11'd0;
      seen_q <= 1'b0;
    end else begin
      lp_prev_q <= line_pulse_out_o;
      rcnt_q <= lp_rise ? {10'd0, rif.pix_en} : rcnt_q + {10'd0, rif.pix_en};
      fcnt_q <= lp_fall ? {10'd0, rif.pix_en} : fcnt_q + {10'd0, rif.pix_en};
      if (pixel_shift_clock_o) begin
        scnt_q <= scnt_q + {10'd0, rif.pix_en};
      end else begin
        scnt_q <= 11'd0;
      end
      if (!active) begin
        seen_q <= 1'b0;
      end else if (lp_rise) begin
        seen_q <= 1'b1;
      end
    end
  end

  a_line_period: assert property (@(posedge clk_i) disable iff (sys_rst_i) // see (RL9)
    lp_rise && seen_q |-> rcnt_q == line_len)
    else $error("line period differs from display plus blank");

  a_lp_width: assert property (@(posedge clk_i) disable iff (sys_rst_i) // see (RL12)
    $fell(line_pulse_out_o) && active |-> rcnt_q >= LPT_LP_TS)
    else $error("line pulse shorter than 9 pixel clocks");

  a_fp_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i) // see (RL11)
    $fell(frame_pulse_out_o) && active |-> fcnt_q >= LPT_HOLD_TS)
    else $error("frame pulse hold after line fall too short");

  a_first_shift: assert property (@(posedge clk_i) disable iff (sys_rst_i) // see (RL14)
    $rose(pixel_shift_clock_o) |-> fcnt_q >= LPT_FIRST_TS)
    else $error("shift clock rose too soon after line fall");

  a_shift_high: assert property (@(posedge clk_i) disable iff (sys_rst_i) // see (RL16)
    $fell(pixel_shift_clock_o) && active
      |-> scnt_q == (ctl_q[LPT_B_8BIT] ? 11'd4 : 11'd2))
    else $error("shift clock high time wrong for data width");

  a_mod_delay: assert property (@(posedge clk_i) disable iff (sys_rst_i) // see (RL13)
    $changed(ac_modulation_o) && active && $past(active) |-> rcnt_q >= 11'd1)
    else $error("modulation changed with the line rise");

  a_ovr_power: assert property (@(posedge clk_i) disable iff (sys_rst_i) // see (RL8)
    ovr |=> !panel_power_enable_o)
    else $error("power on while override set");

  a_run_power: assert property (@(posedge clk_i) disable iff (sys_rst_i) // see (RL4)
    st_q == ST_RUN && !ovr && $past(st_q == ST_RUN && !ovr) |-> panel_power_enable_o)
    else $error("power low while running without override");

  a_drain_state: assert property (@(posedge clk_i) disable iff (sys_rst_i) // see (RL6)
    st_q == ST_DRAIN |-> !panel_power_enable_o && active)
    else $error("draining must keep outputs with power low");

  a_ovr_save: assert property (@(posedge clk_i) disable iff (sys_rst_i) // see (RL5)
    hardware_power_save_i && ovr && en && st_q == ST_RUN |=> !active ##1 !line_pulse_out_o)
    else $error("outputs still active after power save with override");

  // Sequencing edges: outputs, and power except at drain end, checked the cycle after enable, save entry, drain end and wake
  a_start_run: assert property (@(posedge clk_i) disable iff (sys_rst_i) // see (RL3) see (RL4)
    st_q == ST_OFF && en && !hardware_power_save_i
      |=> active && (panel_power_enable_o == !$past(ovr)))
    else $error("outputs or power late after enable");

  a_save_power: assert property (@(posedge clk_i) disable iff (sys_rst_i) // see (RL6)
    st_q == ST_RUN && en && hardware_power_save_i && !ovr |=> active && !panel_power_enable_o)
    else $error("power save entry must drop power and keep outputs");

  a_drain_end: assert property (@(posedge clk_i) disable iff (sys_rst_i) // see (RL6)
    st_q == ST_DRAIN && en && hardware_power_save_i && rif.frame_tick
      && drain_q == LPT_DRAIN_FR - 7'd1 |=> !active)
    else $error("outputs still active after the drain frames");

  a_wake_power: assert property (@(posedge clk_i) disable iff (sys_rst_i) // see (RL7)
    st_q == ST_SAVE && en && !hardware_power_save_i && !ovr |=> active && panel_power_enable_o)
    else $error("outputs and power not restored together");

  // Data may only move on a load, which keeps it clear of the shift fall
  a_data_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i) // see (RL18) see (RL19)
    active && !rif.load |=> $stable(panel_pixel_data_o))
    else $error("panel data changed without a load");
endmodule : lpt_panel_timing
`default_nettype wire

//--- logic/lpt_pkg.sv
/*
  Constants and types shared by the panel timing generator.
  Assumes a single 40 MHz system clock; all panel times count pixel clocks.
*/
`default_nettype none
package lpt_pkg;
  // Register offsets
  localparam logic [4:0] LPT_A_CLK = 5'h02;
  localparam logic [4:0] LPT_A_CTL = 5'h03;
  localparam logic [4:0] LPT_A_HDP = 5'h04;
  localparam logic [4:0] LPT_A_VDPL = 5'h05;
  localparam logic [4:0] LPT_A_VDPH = 5'h06;
  localparam logic [4:0] LPT_A_HORIZONTAL_BLANK_PERIOD = 5'h08;
  localparam logic [4:0] LPT_A_VERTICAL_BLANK_PERIOD = 5'h0A;
  localparam logic [4:0] LPT_A_STAT = 5'h0C;
  // Field positions
  localparam int LPT_B_DIV2 = 4;
  localparam int LPT_B_EN = 0;
  localparam int LPT_B_8BIT = 1;
  localparam int LPT_B_OVR = 2;
  // Clock rates in MHz
  localparam int LPT_CLK_MHZ = 40;
  localparam int LPT_DIV_MHZ = 25;
  // Values after reset
  localparam logic [7:0] LPT_RST_REG = 8'h00;
  localparam logic [7:0] LPT_RST_CLK = (LPT_CLK_MHZ > LPT_DIV_MHZ) ? 8'h10 : 8'h00;
  // Line timing in pixel clocks
  localparam logic [10:0] LPT_LP_TS = 11'd9;
  localparam logic [10:0] LPT_FP_TS = 11'd18;
  localparam logic [10:0] LPT_SHIFT_TS = 11'd32;
  localparam logic [10:0] LPT_HOLD_TS = 11'd9;
  localparam logic [10:0] LPT_FIRST_TS = 11'd23;
  // Frames of drain before outputs stop
  localparam logic [6:0] LPT_DRAIN_FR = 7'd127;
  typedef enum logic [1:0] {ST_OFF, ST_RUN, ST_DRAIN, ST_SAVE} lpt_pwr_e;
endpackage : lpt_pkg
`default_nettype wire

//--- logic/lpt_raster_if.sv
/*
  Carrier between the power/register core and the raster generator.
  Assumes both ends share clk_i.
*/
`timescale 1ns/1ps
`default_nettype none
interface lpt_raster_if;
  logic pix_en;
  logic run;
  logic eight_bit;
  logic [6:0] horizontal_display_period;
  logic [4:0] horizontal_blank_period;
  logic [9:0] vertical_display_period;
  logic [5:0] vertical_blank_period;
  logic line_pulse;
  logic frame_pulse;
  logic shift_clk;
  logic ac_mod;
  logic load;
  logic frame_tick;
  modport ctl (output pix_en, run, eight_bit, horizontal_display_period, horizontal_blank_period, vertical_display_period, vertical_blank_period,
               input line_pulse, frame_pulse, shift_clk, ac_mod, load, frame_tick);
  modport gen (input pix_en, run, eight_bit, horizontal_display_period, horizontal_blank_period, vertical_display_period, vertical_blank_period,
               output line_pulse, frame_pulse, shift_clk, ac_mod, load, frame_tick);
endinterface : lpt_raster_if
`default_nettype wire

//--- logic/lpt_clkdiv.sv
/*
  Pixel clock enable from the system clock, optionally halved.
  Assumes div2_i comes from a register in the same clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module lpt_clkdiv import lpt_pkg::*; (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic div2_i,
  output logic pix_en_o
);
  logic tog_q;

  // Toggle runs always; only used when halving
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      tog_q <= 1'b0;
    end else begin
      tog_q <= ~tog_q;
    end
  end

  assign pix_en_o = div2_i ? tog_q : 1'b1; // see (RL2)
endmodule : lpt_clkdiv
`default_nettype wire

//--- logic/lpt_raster.sv
/*
  Line and frame raster: line pulse, frame pulse, shift clock, modulation.
  Assumes config is stable while run is high; all steps on pix_en.
*/
`timescale 1ns/1ps
`default_nettype none
module lpt_raster import lpt_pkg::*; (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  lpt_raster_if.gen rif
);
  logic [10:0] ct_q;
  logic [10:0] ln_q;
  logic [10:0] hact;
  logic [10:0] hlen;
  logic [10:0] vtot;
  logic [10:0] rel;
  logic last_ct;
  logic last_ln;
  logic in_shift;
  logic lp_q;
  logic fp_q;
  logic sc_q;
  logic mod_q;

  // Line length: display plus blank, both in units of 8
  assign hact = {({1'b0, rif.horizontal_display_period} + 8'd1), 3'b000};
  assign hlen = hact + {2'b00, ({1'b0, rif.horizontal_blank_period} + 6'd4), 3'b000}; // see (RL9) see (RL24)
  assign vtot = {1'b0, rif.vertical_display_period} + 11'd1 + {5'd0, rif.vertical_blank_period}; // see (RL22) see (RL23)
  assign last_ct = (ct_q == hlen - 11'd1);
  assign last_ln = (ln_q == vtot - 11'd1);
  assign rel = ct_q - LPT_SHIFT_TS;
  // No shifting in blank lines
  assign in_shift = (ct_q >= LPT_SHIFT_TS) && (ct_q < LPT_SHIFT_TS + hact)
                    && (ln_q <= {1'b0, rif.vertical_display_period}); // see (RL14)
  assign rif.load = rif.pix_en && rif.run && in_shift
                    && (rif.eight_bit ? (rel[2:0] == 3'd0) : (rel[1:0] == 2'd0));
  assign rif.frame_tick = rif.pix_en && rif.run && last_ct && last_ln;

  // Counters restart whenever the panel goes idle
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || !rif.run) begin
      ct_q <= 11'd0;
      ln_q <= 11'd0;
    end else if (rif.pix_en) begin
      ct_q <= last_ct ? 11'd0 : ct_q + 11'd1;
      if (last_ct) begin
        ln_q <= last_ln ? 11'd0 : ln_q + 11'd1;
      end
    end
  end

  // Outputs are registered from the count, one tick behind it
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || !rif.run) begin
      lp_q <= 1'b0;
      fp_q <= 1'b0;
      sc_q <= 1'b0;
    end else if (rif.pix_en) begin
      lp_q <= (ct_q < LPT_LP_TS); // see (RL12)
      // Rises 9 after previous fall, holds 9 past the next
      fp_q <= (last_ln && ct_q >= LPT_FP_TS) || (ln_q == 11'd0 && ct_q < LPT_FP_TS); // see (RL10) see (RL11)
      sc_q <= in_shift && !(rif.eight_bit ? rel[2] : rel[1]); // see (RL15) see (RL16) see (RL17)
    end
  end

  // Modulation flips once a frame, a tick after the line pulse rises
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      mod_q <= 1'b0;
    end else if (rif.pix_en && rif.run && ln_q == 11'd0 && ct_q == 11'd1) begin
      mod_q <= ~mod_q; // see (RL13)
    end
  end

  assign rif.line_pulse = lp_q;
  assign rif.frame_pulse = fp_q;
  assign rif.shift_clk = sc_q;
  assign rif.ac_mod = mod_q;
endmodule : lpt_raster
`default_nettype wire

//--- verification/lpt_panel_model.sv
/*
  Panel model: hands out pixel bytes on request and times the panel waveforms.
  Assumes panel outputs are synchronous to clk_i; all counts are clk_i cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module lpt_panel_model (
  input wire logic clk_i,
  input wire logic clr_i,
  input wire logic eight_i,
  input wire logic req_i,
  output logic [7:0] pix_o,
  input wire logic line_i,
  input wire logic frame_i,
  input wire logic shift_i,
  input wire logic [7:0] data_i,
  input wire logic mod_i,
  input wire logic mod_pin_i
);
  int t_lr, t_lf, t_sr, t_sf, t_fr, t_chg, t_hd, nsh, psh;
  int line_per, line_hi, sr_dly, sf_dly, sh_hi, sh_per, n_sh, gap_r, gap_f;
  int fp_su, fp_hd, frame_per, mod_dly, su_min, hd_min, bad, lines;
  logic [7:0] cnt, pat, last_q, data_q;
  logic line_q, frame_q, shift_q, mod_q, hd_act, fp_arm;
  // Varying pattern, so a stuck or repeated byte shows
  assign pat = (cnt * 8'h25) + 8'h11;
  // Unrequested, the bus carries the inverse of the last byte, never a copy
  assign pix_o = req_i ? pat : ~last_q;
  initial begin
    cnt = 8'h00;
    last_q = 8'h00;
    data_q = 8'h00;
    {line_q, frame_q, shift_q, mod_q, hd_act, fp_arm} = 6'h00;
  end
  // Edge timers and latched measurements
  always @(posedge clk_i) begin
    {line_q, frame_q, shift_q, mod_q, data_q} <= {line_i, frame_i, shift_i, mod_i, data_i};
    t_lr <= t_lr + 1;
    t_lf <= t_lf + 1;
    t_sr <= t_sr + 1;
    t_sf <= t_sf + 1;
    t_fr <= t_fr + 1;
    t_chg <= t_chg + 1;
    t_hd <= t_hd + 1;
    if (req_i) begin
      last_q <= pat;
      cnt <= cnt + 8'h01;
    end
    if (mod_pin_i !== mod_i) bad <= bad + 1;
    if (line_i && !line_q) begin
      line_per <= t_lr;
      t_lr <= 1;
      lines <= lines + 1;
      psh <= nsh;
      nsh <= 0;
      if (nsh != 0) begin
        n_sh <= nsh;
        gap_r <= t_sf;
      end
    end
    if (!line_i && line_q) begin
      line_hi <= t_lr;
      t_lf <= 1;
      if (psh != 0) gap_f <= t_sf;
      if (fp_arm) fp_su <= t_fr;
      fp_arm <= 1'b0;
    end
    if (frame_i && !frame_q) begin
      frame_per <= t_fr;
      t_fr <= 1;
      fp_arm <= 1'b1;
    end
    if (!frame_i && frame_q) fp_hd <= t_lf;
    if (mod_i !== mod_q) mod_dly <= t_lr;
    if (shift_i && !shift_q) begin
      nsh <= nsh + 1;
      t_sr <= 1;
      if (nsh == 0) sr_dly <= t_lf;
      else sh_per <= t_sr;
    end
    if (!shift_i && shift_q) begin
      sh_hi <= t_sr;
      t_sf <= 1;
      t_hd <= 1;
      hd_act <= 1'b1;
      if (nsh == 1) sf_dly <= t_lf;
      if (data_i !== data_q) su_min <= 0;
      else if (t_chg < su_min) su_min <= t_chg;
      if (data_i !== (eight_i ? last_q : {last_q[3:0], 4'h0})) bad <= bad + 1;
    end
    // Hold is the gap from a shift fall to the next data change
    if (data_i !== data_q) begin
      t_chg <= 1;
      if (hd_act && t_hd < hd_min) hd_min <= t_hd;
      hd_act <= 1'b0;
    end
    if (clr_i) begin
      su_min <= 9999;
      hd_min <= 9999;
      bad <= 0;
    end
  end
endmodule : lpt_panel_model
`default_nettype wire

//--- verification/lpt_panel_timing_tb.sv
/*
  Self-checking bench for the panel timing generator: registers, raster
  timing in both widths, power save and override sequencing.
  Assumes the panel model beside it; halving stays on, so one Ts is 2 clocks.
*/
`timescale 1ns/1ps
`default_nettype none
`define PM i_lpt_panel_model
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin err_total++; \
$display("mismatch %s exp %0d got %0d", n, e, g); end end
module lpt_panel_timing_tb import lpt_pkg::*; ;
  localparam int FR = 288; // Small 4-bit frame: 3 lines of 48 Ts
  logic clk_i, sys_rst_i, reg_wr_i, reg_rd_i, hardware_power_save_i, clr, eight;
  logic pix_req_o, line_pulse_out_o, frame_pulse_out_o, pixel_shift_clock_o;
  logic panel_modulation_out_o, ac_modulation_o, panel_power_enable_o;
  logic [4:0] reg_addr_i;
  logic [7:0] reg_wdata_i, reg_rdata_o, pix_data_i, panel_pixel_data_o;
  int err_total, checks, took, l0;
  // 40 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  lpt_panel_timing i_lpt_panel_timing (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .pix_req_o(pix_req_o),
    .hardware_power_save_i(hardware_power_save_i), .pix_data_i(pix_data_i),
    .line_pulse_out_o(line_pulse_out_o), .frame_pulse_out_o(frame_pulse_out_o),
    .pixel_shift_clock_o(pixel_shift_clock_o), .panel_pixel_data_o(panel_pixel_data_o),
    .panel_modulation_out_o(panel_modulation_out_o), .ac_modulation_o(ac_modulation_o),
    .panel_power_enable_o(panel_power_enable_o));
  lpt_panel_model i_lpt_panel_model (.clk_i(clk_i), .clr_i(clr), .eight_i(eight),
    .req_i(pix_req_o), .pix_o(pix_data_i), .line_i(line_pulse_out_o),
    .frame_i(frame_pulse_out_o), .shift_i(pixel_shift_clock_o),
    .data_i(panel_pixel_data_o), .mod_i(ac_modulation_o), .mod_pin_i(panel_modulation_out_o));
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : conclude
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask : cyc
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    @(posedge clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 `CHK("read data", e, reg_rdata_o)
  endtask : rd
  // Bounded wait for the next line pulse; running out ends the run
  task automatic wait_line(input int lim);
    l0 = `PM.lines;
    took = 0;
    while (`PM.lines == l0) begin
      @(posedge clk_i);
      took++;
      if (took > lim + 4) begin
        `CHK("wait line", lim, took)
        conclude();
      end
    end
  endtask : wait_line
  task automatic stopped;
    l0 = `PM.lines;
    cyc(FR);
    `CHK("lines", l0, `PM.lines)
    `CHK("outputs", 13'h0000, {line_pulse_out_o, frame_pulse_out_o, pixel_shift_clock_o,
      panel_pixel_data_o, ac_modulation_o, panel_modulation_out_o})
  endtask : stopped
  task automatic s_regs;
    rd(LPT_A_CLK, 8'h10);
    rd(LPT_A_CTL, 8'h00);
    wr(LPT_A_HORIZONTAL_BLANK_PERIOD, 8'hE5);
    rd(LPT_A_HORIZONTAL_BLANK_PERIOD, 8'hE5);
    wr(LPT_A_VDPH, 8'h03);
    rd(LPT_A_VDPH, 8'h03);
    wr(5'h1F, 8'hFF);
    rd(5'h1F, 8'h00);
    rd(LPT_A_STAT, 8'h00);
    `CHK("idle power", 1'b0, panel_power_enable_o)
  endtask : s_regs
  // Program a raster, start it and time two frames of it
  task automatic s_run(input logic e8, input int horizontal_display_period, input int hnd, input int vertical_display_period,
                       input int vnd);
    int l;
    int f;
    int hw;
    l = ((horizontal_display_period + 1) * 8 + (hnd % 32 + 4) * 8) * 2;
    f = l * (vertical_display_period + 1 + vnd);
    hw = e8 ? 8 : 4;
    wr(LPT_A_CTL, 8'h00);
    wr(LPT_A_HDP, 8'(horizontal_display_period));
    wr(LPT_A_VDPL, 8'(vertical_display_period));
    wr(LPT_A_VDPH, 8'h00);
    wr(LPT_A_HORIZONTAL_BLANK_PERIOD, 8'(hnd));
    wr(LPT_A_VERTICAL_BLANK_PERIOD, 8'(vnd));
    eight = e8;
    wr(LPT_A_CTL, {6'h00, e8, 1'b1});
    wait_line(f);
    `CHK("start", 1'b1, took <= f)
    `CHK("power", 1'b1, panel_power_enable_o)
    clr <= 1'b1;
    cyc(1);
    clr <= 1'b0;
    cyc(2 * f + l);
    `CHK("line period", l, `PM.line_per)
    `CHK("frame period", f, `PM.frame_per)
    `CHK("line width", 1'b1, `PM.line_hi >= 18)
    `CHK("fp setup", 1'b1, `PM.fp_su >= l - 18)
    `CHK("fp hold", 1'b1, `PM.fp_hd >= 18)
    `CHK("mod delay", 1'b1, `PM.mod_dly >= 2)
    `CHK("first rise", 1'b1, `PM.sr_dly >= 46)
    `CHK("first fall", hw, `PM.sf_dly - `PM.sr_dly)
    `CHK("shift high", hw, `PM.sh_hi)
    `CHK("shift period", 2 * hw, `PM.sh_per)
    `CHK("shifts", (horizontal_display_period + 1) * 8 / hw, `PM.n_sh)
    `CHK("setup", 1'b1, `PM.su_min >= hw)
    `CHK("hold", 1'b1, `PM.hd_min >= hw)
    `CHK("data", 0, `PM.bad)
    `CHK("gap rise", 1'b1, `PM.gap_r >= ((hnd % 32) * 8 + hw / 2) * 2)
    `CHK("gap fall", 1'b1, `PM.gap_f >= ((hnd % 32) * 8 + 9 + hw / 2) * 2)
    rd(LPT_A_STAT, 8'h0C);
  endtask : s_run
  task automatic s_ovr;
    wr(LPT_A_CTL, 8'h05);
    cyc(FR);
    `CHK("override power", 1'b0, panel_power_enable_o)
    hardware_power_save_i <= 1'b1;
    cyc(FR);
    stopped();
    hardware_power_save_i <= 1'b0;
    wait_line(FR);
    `CHK("resume", 1'b1, took <= FR)
    wr(LPT_A_CTL, 8'h01);
    cyc(FR);
    `CHK("power back", 1'b1, panel_power_enable_o)
  endtask : s_ovr
  // Save without override: power first, outputs drain for 127 frames
  task automatic s_drain;
    hardware_power_save_i <= 1'b1;
    cyc(2);
    `CHK("save power", 1'b0, panel_power_enable_o)
    cyc(125 * FR);
    l0 = `PM.lines;
    cyc(FR);
    `CHK("drain runs", 1'b1, `PM.lines > l0)
    cyc(2 * FR);
    stopped();
    hardware_power_save_i <= 1'b0;
    wait_line(FR);
    `CHK("together", 1'b1, panel_power_enable_o)
  endtask : s_drain
  // Halving stays on throughout, as the 40 MHz clock needs
  initial begin
    err_total = 0;
    checks = 0;
    {clr, eight, reg_wr_i, reg_rd_i, hardware_power_save_i} = 5'h00;
    reg_addr_i = 5'h00;
    reg_wdata_i = 8'h00;
    sys_rst_i = 1'b1;
    cyc(12);
    sys_rst_i <= 1'b0;
    s_regs();
    s_run(1'b1, 2, 225, 2, 0);
    s_run(1'b0, 1, 0, 1, 1);
    s_ovr();
    s_drain();
    conclude();
  end
endmodule : lpt_panel_timing_tb
`default_nettype wire
